// ### hdl/cci_pkg.sv
/*
  Constants, register map and carrier types for the comparator change
  interrupt block. Assumes an AXI4-Lite master with 32-bit data.
*/
// Behaviour
// - Change flag sets when either comparator output differs from its latched copy
// - Both comparator outputs read back in control register bits 7:6
// - Change flag sits at bit 6 of the peripheral flag register
// - Only a software write of zero clears the flag; writing one sets it
// - Interrupt enabled only with local, peripheral and global enables all set
// - Flag still sets while any enable is clear
// - A change coinciding with a control register read may miss the flag
// - Any control register access relatches outputs and ends the mismatch
// - Mismatch keeps setting flag; access control register before clearing
// - Comparators run in sleep; enabled change flag wakes the device
// - Waking from sleep leaves the control register unchanged
// - Reset forces the control register to reset state, mode 000
// - Reset mode makes all comparator pins analog inputs
// - Comparators stay powered down throughout reset
// - Global enable is bit 7 of the interrupt control register
package cci_pkg;
  localparam logic [7:0] CCI_OFF_CTRL    = 8'h1f;
  localparam logic [7:0] CCI_OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] CCI_OFF_ENABLES = 8'h8c;
  localparam logic [7:0] CCI_OFF_INTCTL  = 8'h0b;
  localparam logic [7:0] CCI_OFF_SLEEP   = 8'h20;
  localparam int CCI_BIT_OUT2   = 7;
  localparam int CCI_BIT_OUT1   = 6;
  localparam int CCI_BIT_INSEL  = 3;
  localparam int CCI_BIT_FLAG   = 6;
  localparam int CCI_BIT_ENA    = 6;
  localparam int CCI_BIT_PERIPHERAL_IRQ_ENABLE   = 6;
  localparam int CCI_BIT_GIE    = 7;
  localparam int CCI_BIT_SLEEP  = 0;
  localparam logic [2:0] CCI_MODE_RESET = 3'h0;
  localparam logic [2:0] CCI_MODE_OFF   = 3'h7;
  localparam logic [3:0] CCI_CTRL_RST   = 4'h0;
  localparam logic [1:0] CCI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCI_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       in_select;
    logic [2:0] mode;
  } cci_ctrl_t;

  typedef struct packed {
    logic irq_req;
    logic wake;
    logic analog_pins;
    logic powered_down;
  } cci_status_t;
endpackage

// ### hdl/cci_top.sv
/*
  Comparator change interrupt block: AXI4-Lite register slave, output
  latching, change flag, enable gating and sleep wake. Assumes comparator
  outputs are synchronous to aclk.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cci_top
  import cci_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              first_comparator_output,
  input  wire logic              second_comparator_output,
  output logic [2:0]             comparator_mode_field,
  output logic                   comparator_input_select,
  output cci_status_t            status
);
  // Register index comes from address bits 9:2, so a narrower bus cannot reach the map
  initial begin
    if (ADDR_W < 10) $error("ADDR_W too small");
    if (ADDR_W > 32) $error("ADDR_W too large");
    if (CCI_BIT_OUT2 > 7 || CCI_BIT_OUT1 > 7 || CCI_BIT_FLAG > 7) $error("bit position outside the byte");
    if (CCI_BIT_ENA > 7 || CCI_BIT_GIE > 7 || CCI_BIT_PERIPHERAL_IRQ_ENABLE > 7) $error("bit position outside the byte");
    if (CCI_BIT_INSEL != 3 || CCI_BIT_SLEEP > 7) $error("control layout mismatch");
  end

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_EXEC = 3'b010,
    W_RESP = 3'b100
  } cci_wstate_t;

  function automatic logic [7:0] reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = (a[1:0] == 2'h0) ? a[9:2] : 8'hff;
  endfunction

  function automatic logic is_mapped(input logic [7:0] s);
    is_mapped = (s == CCI_OFF_CTRL) || (s == CCI_OFF_FLAGS) || (s == CCI_OFF_ENABLES) ||
                (s == CCI_OFF_INTCTL) || (s == CCI_OFF_SLEEP);
  endfunction

  cci_wstate_t   wst_q;
  logic          aw_got_q;
  logic          w_got_q;
  logic [7:0]    wsel_q;
  logic [7:0]    wdat_q;
  logic          wstrb0_q;
  cci_ctrl_t     ctrl_q;
  logic          flag_q;
  logic          ena_q;
  logic          peripheral_irq_enable_q;
  logic          gie_q;
  logic          sleep_q;
  logic [7:0]    intctl_lo_q;
  logic [7:0]    rsel_q;
  logic          rd_pend_q;
  logic          mismatch;
  logic          wr_do;
  logic          rd_do;
  logic          ctrl_access;
  logic          flag_wr;
  logic          irq_d;
  logic          wake_d;

  logic          wr_ctrl;
  logic          wr_enables;
  logic          wr_intctl;
  logic          wr_sleep;
  logic          rd_ctrl;

  logic [1:0]    cmp_live;
  logic [1:0]    cmp_lat_q;
  logic [1:0]    cmp_diff;
  logic [7:0]    rbyte;

  // Write strobe for one register; only byte lane 0 carries data
  function automatic logic wr_hit(input logic [7:0] s, input logic [7:0] off, input logic go, input logic lane0);
    wr_hit = go && lane0 && (s == off);
  endfunction

  assign wr_do      = (wst_q == W_EXEC);
  assign rd_do      = rd_pend_q && !s_axi_rvalid;
  assign flag_wr    = wr_hit(wsel_q, CCI_OFF_FLAGS, wr_do, wstrb0_q);
  assign wr_ctrl    = wr_hit(wsel_q, CCI_OFF_CTRL, wr_do, wstrb0_q);
  assign wr_enables = wr_hit(wsel_q, CCI_OFF_ENABLES, wr_do, wstrb0_q);
  assign wr_intctl  = wr_hit(wsel_q, CCI_OFF_INTCTL, wr_do, wstrb0_q);
  assign wr_sleep   = wr_hit(wsel_q, CCI_OFF_SLEEP, wr_do, wstrb0_q);
  assign rd_ctrl    = rd_do && (rsel_q == CCI_OFF_CTRL);

  // Mismatch ends on any access, read or write, of the control register
  // A write with lane 0 off still counts as an access
  assign ctrl_access = (wr_do && wsel_q == CCI_OFF_CTRL) || rd_ctrl;
  assign cmp_live    = {second_comparator_output, first_comparator_output};
  assign mismatch    = |cmp_diff;
  assign irq_d       = flag_q && ena_q && peripheral_irq_enable_q && gie_q;
  // Wake ignores the global enable, so a masked core still leaves sleep
  assign wake_d      = sleep_q && flag_q && ena_q && peripheral_irq_enable_q;

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q         <= W_IDLE;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      wsel_q        <= 8'h00;
      wdat_q        <= 8'h00;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CCI_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wst_q)
        W_IDLE: begin
          if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_got_q      <= 1'b1;
            wsel_q        <= reg_sel(s_axi_awaddr);
          end
          if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_got_q      <= 1'b1;
            wdat_q       <= s_axi_wdata[7:0];
            wstrb0_q     <= s_axi_wstrb[0];
          end
          if (aw_got_q && w_got_q) begin
            wst_q <= W_EXEC;
          end
        end
        W_EXEC: begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp  <= is_mapped(wsel_q) ? CCI_RESP_OKAY : CCI_RESP_SLVERR;
          wst_q        <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            wst_q        <= W_IDLE;
          end
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  // Read channel: one read under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q     <= 1'b0;
      rsel_q        <= 8'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CCI_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !rd_pend_q && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        rd_pend_q     <= 1'b1;
        rsel_q        <= reg_sel(s_axi_araddr);
      end
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rbyte};
        s_axi_rresp  <= is_mapped(rsel_q) ? CCI_RESP_OKAY : CCI_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        rd_pend_q    <= 1'b0;
      end
    end
  end

  // Live outputs read back in the top bits; the read also relatches them
  always_comb begin
    rbyte = 8'h00;
    case (rsel_q)
      CCI_OFF_CTRL: begin
        rbyte[CCI_BIT_OUT2] = second_comparator_output;
        rbyte[CCI_BIT_OUT1] = first_comparator_output;
        rbyte[CCI_BIT_INSEL:0] = ctrl_q;
      end
      CCI_OFF_FLAGS:   rbyte[CCI_BIT_FLAG] = flag_q;
      CCI_OFF_ENABLES: rbyte[CCI_BIT_ENA]  = ena_q;
      CCI_OFF_INTCTL:  rbyte = {gie_q, peripheral_irq_enable_q, intctl_lo_q[5:0]};
      CCI_OFF_SLEEP:   rbyte[CCI_BIT_SLEEP] = sleep_q;
      default:         rbyte = 8'h00;
    endcase
  end

  // Reset forces mode 000; sleep and wake never touch this register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CCI_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdat_q[CCI_BIT_INSEL:0];
    end
  end

  // One latch per comparator; a change in the access cycle is absorbed, so may not flag
  for (genvar i = 0; i < 2; i++) begin : g_lat
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_lat_q[i] <= 1'b0;
      end else if (ctrl_access) begin
        cmp_lat_q[i] <= cmp_live[i];
      end
    end

    assign cmp_diff[i] = (cmp_live[i] != cmp_lat_q[i]);
  end

  // Hardware set wins over software clear; enables play no part here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (mismatch && !ctrl_access) begin
      flag_q <= 1'b1;
    end else if (flag_wr) begin
      flag_q <= wdat_q[CCI_BIT_FLAG];
    end
  end

  // Local comparator enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_q <= 1'b0;
    end else if (wr_enables) begin
      ena_q <= wdat_q[CCI_BIT_ENA];
    end
  end

  // Global and peripheral enables; low bits are plain storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_irq_enable_q      <= 1'b0;
      gie_q       <= 1'b0;
      intctl_lo_q <= 8'h00;
    end else if (wr_intctl) begin
      gie_q       <= wdat_q[CCI_BIT_GIE];
      peripheral_irq_enable_q      <= wdat_q[CCI_BIT_PERIPHERAL_IRQ_ENABLE];
      intctl_lo_q <= {2'h0, wdat_q[5:0]};
    end
  end

  // Sleep set by software, dropped by an enabled wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= 1'b0;
    end else if (wake_d) begin
      sleep_q <= 1'b0;
    end else if (wr_sleep) begin
      sleep_q <= wdat_q[CCI_BIT_SLEEP];
    end
  end

  // Pin-side mode and select, registered so the pins never glitch mid-write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_mode_field   <= CCI_MODE_RESET;
      comparator_input_select <= 1'b0;
    end else begin
      comparator_mode_field   <= ctrl_q.mode;
      comparator_input_select <= ctrl_q.in_select;
    end
  end

  // Request to the core one cycle after the gate opens
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status.irq_req <= 1'b0;
    end else begin
      status.irq_req <= irq_d;
    end
  end

  // Wake is a pulse; sleep drops in the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status.wake <= 1'b0;
    end else begin
      status.wake <= wake_d;
    end
  end

  // Reset mode keeps every comparator pin analog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status.analog_pins <= 1'b1;
    end else begin
      status.analog_pins <= (ctrl_q.mode == CCI_MODE_RESET);
    end
  end

  // Power-down held through reset
  // Mode 111 turns comparators off, the low-power choice for sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status.powered_down <= 1'b1;
    end else begin
      status.powered_down <= (ctrl_q.mode == CCI_MODE_OFF);
    end
  end
endmodule
`default_nettype wire

// ### verif/cci_cmp_model.sv
/*
  Comparator pair model: drives both outputs from a bench level.
  Assumes outputs change just after aclk, as real synchronised comparators.
*/
`timescale 1ns/100ps
`default_nettype none
module cci_cmp_model (
  input  wire logic       aclk,
  input  wire logic [1:0] level,
  output logic            first_comparator_output,
  output logic            second_comparator_output
);
  // Registered so outputs never move on the sampling edge
  always_ff @(posedge aclk) begin
    first_comparator_output  <= level[0];
    second_comparator_output <= level[1];
  end
endmodule
`default_nettype wire

// ### verif/cci_top_asserts.sv
/*
  Checker for cci_top port behaviour.
  Assumes binding onto cci_top, one clock aclk, sync reset aresetn.
*/
`timescale 1ns/100ps
`default_nettype none
module cci_top_asserts
  import cci_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0]  comparator_mode_field,
  input wire cci_status_t status
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (s_aw_taken |-> ##[1:4] s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
  analog_pins_a: assert property ($past(aresetn) |-> status.analog_pins == (comparator_mode_field == CCI_MODE_RESET))
    else $error("analog pins not tied to reset mode");
  power_down_a: assert property ($past(aresetn) |-> status.powered_down == (comparator_mode_field == CCI_MODE_OFF))
    else $error("power down not tied to off mode");
  reset_mode_a: assert property ($rose(aresetn) |-> $past(status.powered_down) && comparator_mode_field == CCI_MODE_RESET)
    else $error("reset state wrong");
endmodule
bind cci_top cci_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench for cci_top over AXI4-Lite.
  Assumes the comparator model and checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import cci_pkg::*;
  localparam logic [11:0] A_CTRL = 12'(CCI_OFF_CTRL) << 2;
  localparam logic [11:0] A_FLG  = 12'(CCI_OFF_FLAGS) << 2;
  localparam logic [11:0] A_ENA  = 12'(CCI_OFF_ENABLES) << 2;
  localparam logic [11:0] A_INT  = 12'(CCI_OFF_INTCTL) << 2;
  localparam logic [11:0] A_SLP  = 12'(CCI_OFF_SLEEP) << 2;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, c1, c2, sel, seen;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r, lvl = 0;
  logic [2:0]  mode;
  cci_status_t status;
  int fails = 0, checks = 0, cyc = 0;
  always #25 aclk = ~aclk;
  cci_cmp_model u_cmp (.aclk(aclk), .level(lvl), .first_comparator_output(c1), .second_comparator_output(c2));
  cci_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_comparator_output(c1),
    .second_comparator_output(c2), .comparator_mode_field(mode), .comparator_input_select(sel), .status(status));
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready) begin ad = 1; awvalid <= 0; end
      if (wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, CCI_RESP_OKAY)
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] v);
    wr(a, v, r);
    `CHK(r, CCI_RESP_OKAY)
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ceiling well above the roughly 140 cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin fails++; stop_test(); end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rdc(A_CTRL, 32'h0);
    `CHK(status.analog_pins, 1'b1)
    $display("reset test done");
    lvl <= 2'b01;
    repeat (3) @(posedge aclk);
    rdc(A_FLG, 32'h40);
    `CHK(status.irq_req, 1'b0)
    wrc(A_FLG, 32'h0);
    rdc(A_FLG, 32'h40);
    rdc(A_CTRL, 32'h40);
    wrc(A_FLG, 32'h0);
    rdc(A_FLG, 32'h0);
    $display("change test done");
    wrc(A_FLG, 32'h40);
    wrc(A_ENA, 32'h40);
    wrc(A_INT, 32'h40);
    rdc(A_FLG, 32'h40);
    `CHK(status.irq_req, 1'b0)
    wrc(A_INT, 32'hc0);
    rdc(A_INT, 32'hc0);
    `CHK(status.irq_req, 1'b1)
    wrc(A_FLG, 32'h0);
    wrc(A_INT, 32'h40);
    @(negedge aclk);
    `CHK(status.irq_req, 1'b0)
    $display("gating test done");
    wrc(A_CTRL, 32'h7);
    @(negedge aclk);
    `CHK(status.powered_down, 1'b1)
    wrc(A_SLP, 32'h1);
    lvl <= 2'b11;
    seen = 0;
    repeat (20) begin
      @(posedge aclk);
      if (status.wake === 1'b1) seen = 1;
    end
    `CHK(seen, 1'b1)
    rdc(A_SLP, 32'h0);
    rdc(A_CTRL, 32'hc7);
    rd(12'h3f0, d, r);
    `CHK(r, CCI_RESP_SLVERR)
    wr(12'h031, 32'h1, r);
    `CHK(r, CCI_RESP_SLVERR)
    $display("sleep test done");
    @(posedge aclk);
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rdc(A_CTRL, 32'hc0);
    `CHK(status.powered_down, 1'b0)
    $display("second reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
